// file: common/hpdfg_pkg.sv
// Purpose: Shared constants for the host port decoder with fast gate generator.
// Assumes: APB register bus with 16-bit byte addresses and 32-bit data.
// Notes: All offsets are byte addresses of aligned 32-bit words.
package hpdfg_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BYTE_W = 8;

  // Register byte addresses.
  localparam logic [15:0] ADDR_CHAN1_OUT = 16'hff00;
  localparam logic [15:0] ADDR_CHAN2_OUT = 16'hff04;
  localparam logic [15:0] ADDR_CHAN1_IN = 16'hff08;
  localparam logic [15:0] ADDR_CHAN2_IN = 16'hff0c;
  localparam logic [15:0] ADDR_CHAN1_STAT = 16'hff10;
  localparam logic [15:0] ADDR_CHAN2_STAT = 16'hff14;
  localparam logic [15:0] ADDR_IRQ_STATUS = 16'hff18;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'hff1c;
  localparam logic [15:0] ADDR_GATE_PORT = 16'hff20;
  localparam logic [15:0] ADDR_SYS_CONTROL = 16'hffc4;
  localparam logic [15:0] ADDR_HOST_PORT_CONTROL = 16'hfff0;

  // Status register fields.
  localparam int unsigned STAT_OBF_BIT = 0;
  localparam int unsigned STAT_INPUT_FULL_BIT = 1;
  localparam int unsigned STAT_CMD_BIT = 3;
  localparam logic [7:0] STAT_USER_MASK = 8'hf4;

  // Control fields.
  localparam int unsigned FAST_GATE_ENABLE_BIT = 0;
  localparam int unsigned HOST_PORT_ENABLE_BIT = 1;
  localparam int unsigned GATE_DATA_BIT = 0;
  localparam int unsigned GATE_DIR_BIT = 1;
  localparam int unsigned GATE_SEL_DATA_BIT = 1;

  // Interrupt status fields.
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_CHAN1_FULL_BIT = 0;
  localparam int unsigned IRQ_CHAN2_FULL_BIT = 1;

  // Gate commands.
  localparam logic [7:0] CMD_GATE_WRITE = 8'hd1;
  localparam logic [7:0] CMD_GATE_NOP = 8'hff;

  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_GATE_PORT = 2'h1;
  localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;

  typedef enum logic [1:0] {
    FG_IDLE,
    FG_WAIT_DATA,
    FG_AFTER_DATA
  } hpdfg_fg_state_t;
endpackage : hpdfg_pkg

// file: logic/hpdfg_top.sv
// Purpose: Slave side of a two-channel 8-bit host port with a hardware fast gate generator.
// Assumes: Host pins are synchronous to pclk; registers are reached over APB.
// Notes: Host writes commit on the rising edge of the write strobe, seen one cycle late.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns

// What this block does
// (RL1) Channel-1 select, read low, address low: drive channel-1 output data on host bus.
// (RL2) Channel-1 select, read low, address high: drive channel-1 status on host bus.
// (RL3) Channel-1 select, write low, address low: capture byte as data.
// (RL4) Channel-1 select, write low, address high: capture byte as command.
// (RL5) Channel-2 select, read low: drive channel-2 output data or status by address bit.
// (RL6) Channel-2 select, write low: capture byte, marked data or command by address bit.
// (RL7) Host never drives both strobes low; both high leaves channel idle.
// (RL8) Hardware gate generation only while fast gate enable bit is one.
// (RL9) In regular mode software copies data bit 1 after a D1 command.
// (RL10) Software sets gate pin direction to one so the gate drives out.
// (RL11) After enabling, gate output starts at the port data bit 0 value.
// (RL12) Gate decoding only on channel-1 writes; channel 2 never touches the gate.
// (RL13) Data after D1 sets or clears gate from bit 1 on write-strobe rise.
// (RL14) D1, its data and trailing FF are consumed without raising the input-full flag.
// (RL15) Other command after a D1 data pair raises the flag, gate unchanged.
// (RL16) Non-D1 command after D1 cancels and raises the flag; repeated D1 restarts.
// (RL17) Input-full flag sets on write-strobe rise, clears when slave reads input data.
// (RL18) Whole host port active, pins claimed, only while host port enable is one.
module hpdfg_top
  import hpdfg_pkg::*;
(
  input wire logic pclk, // Bus clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [ADDR_W-1:0] paddr, // APB byte address.
  input wire logic [DATA_W-1:0] pwdata, // APB write data.
  output logic [DATA_W-1:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped address.
  input wire logic chan1_select_n, // Host channel-1 select.
  input wire logic chan2_select_n, // Host channel-2 select.
  input wire logic host_read_strobe_n, // Host read strobe.
  input wire logic host_write_strobe_n, // Host write strobe.
  input wire logic host_addr_bit, // Host address bit.
  input wire logic [BYTE_W-1:0] host_data_in, // Host data bus as seen on the pins.
  output logic [BYTE_W-1:0] host_data_out, // Host data bus driven value.
  output logic host_data_oe, // High while the host data bus is driven.
  output logic gate_output_pin, // Gate pin output value.
  output logic gate_output_oe, // High while the gate pin is driven.
  output logic irq // Level interrupt to the slave processor.
);

  // Register state.
  logic [BYTE_W-1:0] chan1_output_data_q, chan2_output_data_q, chan1_input_data_q, chan2_input_data_q;
  logic [BYTE_W-1:0] chan1_status_q, chan2_status_q;
  logic [IRQ_W-1:0] irq_status_q, irq_mask_q;
  logic [1:0] gate_port_q;
  logic fast_gate_enable_q, host_port_enable_q, gate_q, fast_gate_enable_prev_q;
  hpdfg_fg_state_t fg_state_q;

  // Host write capture state.
  logic wr_strobe_prev_q, rd_strobe_prev_q, wr_chan1_q, wr_chan2_q, wr_cmd_q;
  logic [BYTE_W-1:0] wr_byte_q;
  logic rd_chan1_q, rd_chan2_q, rd_addr_q;

  // Host side decode.
  logic chan1_sel, chan2_sel, host_rd, host_wr, wr_commit, rd_commit;
  logic commit1, commit2, fg_consume, chan1_full_set, chan2_full_set;

  // APB decode.
  logic apb_done, apb_wr, apb_rd, hit_d;
  logic [DATA_W-1:0] rdata_d;

  // Exactly one channel selected; both selects low is not a valid access.
  assign chan1_sel = host_port_enable_q && !chan1_select_n && chan2_select_n; // see (RL18)
  assign chan2_sel = host_port_enable_q && !chan2_select_n && chan1_select_n; // see (RL18)
  assign host_rd = !host_read_strobe_n && host_write_strobe_n; // see (RL7)
  assign host_wr = !host_write_strobe_n && host_read_strobe_n; // see (RL7)
  assign wr_commit = !wr_strobe_prev_q && host_write_strobe_n;
  assign rd_commit = !rd_strobe_prev_q && host_read_strobe_n;
  assign commit1 = wr_commit && wr_chan1_q;
  assign commit2 = wr_commit && wr_chan2_q;

  // Strobe history for rising-edge detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_strobe_prev_q <= 1'b1;
      rd_strobe_prev_q <= 1'b1;
    end else begin
      wr_strobe_prev_q <= host_write_strobe_n;
      rd_strobe_prev_q <= host_read_strobe_n;
    end
  end

  // Latch what the host presents while the write strobe is low; commit on its rise.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_chan1_q <= 1'b0;
      wr_chan2_q <= 1'b0;
      wr_cmd_q <= 1'b0;
      wr_byte_q <= RST_BYTE;
    end else if (!host_write_strobe_n) begin
      wr_chan1_q <= chan1_sel && host_wr; // see (RL3) (RL4)
      wr_chan2_q <= chan2_sel && host_wr; // see (RL6)
      wr_cmd_q <= host_addr_bit;
      wr_byte_q <= host_data_in;
    end else if (wr_commit) begin
      wr_chan1_q <= 1'b0;
      wr_chan2_q <= 1'b0;
    end
  end

  // Latch the read target while the read strobe is low, for the flag clear on its rise.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_chan1_q <= 1'b0;
      rd_chan2_q <= 1'b0;
      rd_addr_q <= 1'b0;
    end else if (!host_read_strobe_n) begin
      rd_chan1_q <= chan1_sel && host_rd;
      rd_chan2_q <= chan2_sel && host_rd;
      rd_addr_q <= host_addr_bit;
    end else if (rd_commit) begin
      rd_chan1_q <= 1'b0;
      rd_chan2_q <= 1'b0;
    end
  end

  // Drive the host bus from the selected output or status register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_data_out <= RST_BYTE;
      host_data_oe <= 1'b0;
    end else begin
      host_data_oe <= (chan1_sel || chan2_sel) && host_rd; // see (RL18)
      if (chan1_sel && !host_addr_bit) begin
        host_data_out <= chan1_output_data_q; // see (RL1)
      end else if (chan1_sel) begin
        host_data_out <= chan1_status_q; // see (RL2)
      end else if (chan2_sel && !host_addr_bit) begin
        host_data_out <= chan2_output_data_q; // see (RL5)
      end else if (chan2_sel) begin
        host_data_out <= chan2_status_q; // see (RL5)
      end
    end
  end

  // Fast gate sequence decoder; true when the committed channel-1 byte is consumed.
  always_comb begin
    fg_consume = 1'b0;
    if (fast_gate_enable_q && commit1) begin // see (RL8) (RL12)
      if (wr_cmd_q && wr_byte_q == CMD_GATE_WRITE) begin
        fg_consume = 1'b1; // see (RL14) (RL16)
      end else if (fg_state_q == FG_WAIT_DATA && !wr_cmd_q) begin
        fg_consume = 1'b1; // see (RL14)
      end else if (fg_state_q == FG_AFTER_DATA && wr_cmd_q && wr_byte_q == CMD_GATE_NOP) begin
        fg_consume = 1'b1; // see (RL14)
      end
    end
  end

  // Sequence state of the fast gate generator.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fg_state_q <= FG_IDLE;
    end else if (!fast_gate_enable_q) begin
      fg_state_q <= FG_IDLE;
    end else if (commit1) begin
      case (fg_state_q)
        FG_WAIT_DATA: begin
          if (!wr_cmd_q) begin
            fg_state_q <= FG_AFTER_DATA;
          end else if (wr_byte_q != CMD_GATE_WRITE) begin
            fg_state_q <= FG_IDLE; // see (RL16)
          end
        end
        default: begin
          if (wr_cmd_q && wr_byte_q == CMD_GATE_WRITE) begin
            fg_state_q <= FG_WAIT_DATA;
          end else begin
            fg_state_q <= FG_IDLE; // see (RL15)
          end
        end
      endcase
    end
  end

  // Gate value: preset from port data on enable, then updated by data after D1.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_q <= RST_GATE_PORT[GATE_DATA_BIT];
      fast_gate_enable_prev_q <= 1'b0;
    end else begin
      fast_gate_enable_prev_q <= fast_gate_enable_q;
      if (!fast_gate_enable_q || !fast_gate_enable_prev_q) begin
        gate_q <= gate_port_q[GATE_DATA_BIT]; // see (RL11)
      end else if (commit1 && fg_state_q == FG_WAIT_DATA && !wr_cmd_q) begin
        gate_q <= wr_byte_q[GATE_SEL_DATA_BIT]; // see (RL13)
      end
    end
  end

  // Gate pin: hardware value in fast mode, software port value otherwise.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_output_pin <= RST_GATE_PORT[GATE_DATA_BIT];
      gate_output_oe <= 1'b0;
    end else begin
      gate_output_pin <= fast_gate_enable_q ? gate_q : gate_port_q[GATE_DATA_BIT]; // see (RL8) (RL9)
      gate_output_oe <= gate_port_q[GATE_DIR_BIT]; // see (RL10)
    end
  end

  // APB handshake: one wait-free access phase after each setup cycle.
  assign apb_done = psel && penable && pready;
  assign apb_wr = apb_done && pwrite;
  assign apb_rd = apb_done && !pwrite;
  assign chan1_full_set = commit1 && !fg_consume; // see (RL14) (RL15) (RL16)
  assign chan2_full_set = commit2;

  // Channel input data, loaded on each host write commit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan1_input_data_q <= RST_BYTE;
      chan2_input_data_q <= RST_BYTE;
    end else begin
      if (commit1) begin
        chan1_input_data_q <= wr_byte_q; // see (RL3) (RL4)
      end
      if (commit2) begin
        chan2_input_data_q <= wr_byte_q; // see (RL6)
      end
    end
  end

  // Status registers; hardware set wins over slave read clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan1_status_q <= RST_BYTE;
      chan2_status_q <= RST_BYTE;
    end else begin
      if (apb_wr && paddr == ADDR_CHAN1_STAT) begin
        chan1_status_q <= (chan1_status_q & ~STAT_USER_MASK) | (pwdata[BYTE_W-1:0] & STAT_USER_MASK);
      end
      if (apb_wr && paddr == ADDR_CHAN2_STAT) begin
        chan2_status_q <= (chan2_status_q & ~STAT_USER_MASK) | (pwdata[BYTE_W-1:0] & STAT_USER_MASK);
      end
      if (commit1) begin
        chan1_status_q[STAT_CMD_BIT] <= wr_cmd_q; // see (RL3) (RL4)
      end
      if (commit2) begin
        chan2_status_q[STAT_CMD_BIT] <= wr_cmd_q; // see (RL6)
      end
      if (chan1_full_set) begin
        chan1_status_q[STAT_INPUT_FULL_BIT] <= 1'b1; // see (RL17)
      end else if (apb_rd && paddr == ADDR_CHAN1_IN) begin
        chan1_status_q[STAT_INPUT_FULL_BIT] <= 1'b0; // see (RL17)
      end
      if (chan2_full_set) begin
        chan2_status_q[STAT_INPUT_FULL_BIT] <= 1'b1;
      end else if (apb_rd && paddr == ADDR_CHAN2_IN) begin
        chan2_status_q[STAT_INPUT_FULL_BIT] <= 1'b0;
      end
      if (apb_wr && paddr == ADDR_CHAN1_OUT) begin
        chan1_status_q[STAT_OBF_BIT] <= 1'b1;
      end else if (rd_commit && rd_chan1_q && !rd_addr_q) begin
        chan1_status_q[STAT_OBF_BIT] <= 1'b0;
      end
      if (apb_wr && paddr == ADDR_CHAN2_OUT) begin
        chan2_status_q[STAT_OBF_BIT] <= 1'b1;
      end else if (rd_commit && rd_chan2_q && !rd_addr_q) begin
        chan2_status_q[STAT_OBF_BIT] <= 1'b0;
      end
    end
  end

  // Software-written control and output registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan1_output_data_q <= RST_BYTE;
      chan2_output_data_q <= RST_BYTE;
      irq_mask_q <= RST_IRQ;
      gate_port_q <= RST_GATE_PORT;
      fast_gate_enable_q <= 1'b0;
      host_port_enable_q <= 1'b0;
    end else if (apb_wr) begin
      if (paddr == ADDR_CHAN1_OUT) begin
        chan1_output_data_q <= pwdata[BYTE_W-1:0];
      end else if (paddr == ADDR_CHAN2_OUT) begin
        chan2_output_data_q <= pwdata[BYTE_W-1:0];
      end else if (paddr == ADDR_IRQ_MASK) begin
        irq_mask_q <= pwdata[IRQ_W-1:0];
      end else if (paddr == ADDR_GATE_PORT) begin
        gate_port_q <= pwdata[1:0];
      end else if (paddr == ADDR_HOST_PORT_CONTROL) begin
        fast_gate_enable_q <= pwdata[FAST_GATE_ENABLE_BIT]; // see (RL8)
      end else if (paddr == ADDR_SYS_CONTROL) begin
        host_port_enable_q <= pwdata[HOST_PORT_ENABLE_BIT]; // see (RL18)
      end
    end
  end

  // Sticky input-full interrupt events; a read clears, a same-cycle set wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= RST_IRQ;
      irq <= 1'b0;
    end else begin
      if (apb_rd && paddr == ADDR_IRQ_STATUS) begin
        irq_status_q <= {chan2_full_set, chan1_full_set};
      end else begin
        irq_status_q <= irq_status_q | {chan2_full_set, chan1_full_set}; // see (RL17)
      end
      irq <= |(irq_status_q & irq_mask_q);
    end
  end

  // Read data mux for the APB slave.
  always_comb begin
    rdata_d = '0;
    hit_d = 1'b1;
    if (paddr == ADDR_CHAN1_OUT) begin
      rdata_d[BYTE_W-1:0] = chan1_output_data_q;
    end else if (paddr == ADDR_CHAN2_OUT) begin
      rdata_d[BYTE_W-1:0] = chan2_output_data_q;
    end else if (paddr == ADDR_CHAN1_IN) begin
      rdata_d[BYTE_W-1:0] = chan1_input_data_q;
    end else if (paddr == ADDR_CHAN2_IN) begin
      rdata_d[BYTE_W-1:0] = chan2_input_data_q;
    end else if (paddr == ADDR_CHAN1_STAT) begin
      rdata_d[BYTE_W-1:0] = chan1_status_q;
    end else if (paddr == ADDR_CHAN2_STAT) begin
      rdata_d[BYTE_W-1:0] = chan2_status_q;
    end else if (paddr == ADDR_IRQ_STATUS) begin
      rdata_d[IRQ_W-1:0] = irq_status_q;
    end else if (paddr == ADDR_IRQ_MASK) begin
      rdata_d[IRQ_W-1:0] = irq_mask_q;
    end else if (paddr == ADDR_GATE_PORT) begin
      rdata_d[1:0] = gate_port_q;
    end else if (paddr == ADDR_HOST_PORT_CONTROL) begin
      rdata_d[FAST_GATE_ENABLE_BIT] = fast_gate_enable_q;
    end else if (paddr == ADDR_SYS_CONTROL) begin
      rdata_d[HOST_PORT_ENABLE_BIT] = host_port_enable_q;
    end else begin
      hit_d = 1'b0;
    end
  end

  // Answer registered in the setup cycle so the access phase completes at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit_d;
      prdata <= (psel && !penable && !pwrite) ? rdata_d : '0;
    end
  end

endmodule : hpdfg_top

// file: test/hpdfg_properties.sv
// Purpose: Concurrent checks on the host port decoder ports.
// Assumes: One clock domain; figures follow the hand-over latencies.
// Notes: Bound into hpdfg_top below the module.
`timescale 1ns/1ns
module hpdfg_properties
  import hpdfg_pkg::*;
(
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset.
  input wire logic psel, // Select.
  input wire logic penable, // Enable.
  input wire logic pwrite, // Direction.
  input wire logic [ADDR_W-1:0] paddr, // Address.
  input wire logic [DATA_W-1:0] pwdata, // Write data.
  input wire logic [DATA_W-1:0] prdata, // Read data.
  input wire logic pready, // Ready.
  input wire logic pslverr, // Error.
  input wire logic chan1_select_n, // Channel-1 select.
  input wire logic chan2_select_n, // Channel-2 select.
  input wire logic host_read_strobe_n, // Read strobe.
  input wire logic host_write_strobe_n, // Write strobe.
  input wire logic host_addr_bit, // Address bit.
  input wire logic [BYTE_W-1:0] host_data_in, // Host bus.
  input wire logic [BYTE_W-1:0] host_data_out, // Driven byte.
  input wire logic host_data_oe, // Drive enable.
  input wire logic gate_output_pin, // Gate value.
  input wire logic gate_output_oe, // Gate enable.
  input wire logic irq // Interrupt.
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Decoded host and bus activity used by several checks.
  wire apb_wr = psel && penable && pwrite;
  wire c1_wr = !chan1_select_n && !host_write_strobe_n;
  wire one_rd = !host_read_strobe_n && host_write_strobe_n && (chan1_select_n != chan2_select_n);

  // Bus handshake, host drive and event timing.
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_in_access: assert property (pready |-> psel && penable && $past(psel && !penable))
    else $error("ready outside access phase");
  chk_err_no_data: assert property (pslverr |-> pready && prdata == '0)
    else $error("error without ready or with data");
  chk_oe_needs_read: assert property (host_data_oe |-> $past(one_rd))
    else $error("host bus driven without a read");
  chk_idle_no_drive: assert property (host_read_strobe_n |=> !host_data_oe)
    else $error("host bus driven while idle");
  chk_oe_holds: assert property (host_data_oe && one_rd |=> host_data_oe)
    else $error("host drive dropped during read");
  chk_irq_rise_cause: assert property ($rose(irq) |->
    ($past(host_write_strobe_n, 2) && !$past(host_write_strobe_n, 3)) || $past(apb_wr, 2))
    else $error("interrupt rose without a host write");
  chk_irq_fall_cause: assert property ($fell(irq) |-> $past(psel && penable, 2))
    else $error("interrupt fell without a bus access");
  chk_gate_cause: assert property ($changed(gate_output_pin) |->
    $past(c1_wr, 3) || $past(apb_wr, 2) || $past(apb_wr, 3))
    else $error("gate changed without a channel-1 write");

  // Main scenarios reached.
  cov_irq: cover property ($rose(irq));
  cov_gate: cover property ($changed(gate_output_pin) && gate_output_oe);
  cov_read: cover property (host_data_oe);
  cov_err: cover property (pslverr);
endmodule : hpdfg_properties

bind hpdfg_top hpdfg_properties chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .chan1_select_n, .chan2_select_n, .host_read_strobe_n, .host_write_strobe_n,
  .host_addr_bit, .host_data_in, .host_data_out, .host_data_oe, .gate_output_pin, .gate_output_oe, .irq);

// file: test/hpdfg_host_model.sv
// Purpose: Host processor model for the parallel host port.
// Assumes: Pins change just after a rising pclk edge.
// Notes: A released data bus shows the inverse of the last host byte.
`timescale 1ns/1ns
module hpdfg_host_model
  import hpdfg_pkg::*;
(
  input wire logic pclk, // Clock.
  output logic chan1_select_n, // Channel-1 select.
  output logic chan2_select_n, // Channel-2 select.
  output logic host_read_strobe_n, // Read strobe.
  output logic host_write_strobe_n, // Write strobe.
  output logic host_addr_bit, // Address bit.
  output logic [BYTE_W-1:0] host_data_in, // Bus level.
  input wire logic [BYTE_W-1:0] host_data_out, // Device byte.
  input wire logic host_data_oe // Device drive.
);
  logic [BYTE_W-1:0] drv_q = 8'h00;
  logic drv_en = 1'b0;
  // The device drive wins, then the host byte, else the released level.
  assign host_data_in = host_data_oe ? host_data_out : (drv_en ? drv_q : ~drv_q);

  // Pins start idle with no channel selected.
  initial begin
    {chan1_select_n, chan2_select_n, host_read_strobe_n, host_write_strobe_n} = 4'hf;
    host_addr_bit = 1'b0;
  end

  // One write; the select is held through the strobe rise.
  task automatic wr(input int ch, input logic a0, input logic [7:0] b);
    @(posedge pclk);
    {chan1_select_n, chan2_select_n} <= {ch != 1, ch != 2};
    host_addr_bit <= a0;
    drv_q <= b;
    drv_en <= 1'b1;
    host_write_strobe_n <= 1'b0; // Read strobe stays high
    @(posedge pclk);
    host_write_strobe_n <= 1'b1;
    @(posedge pclk);
    {chan1_select_n, chan2_select_n} <= 2'b11;
    drv_en <= 1'b0;
  endtask : wr

  // One read; returns the drive enable above the byte seen.
  task automatic rd(input int ch, input logic a0, output logic [8:0] r);
    @(posedge pclk);
    {chan1_select_n, chan2_select_n} <= {ch != 1, ch != 2};
    host_addr_bit <= a0;
    host_read_strobe_n <= 1'b0; // Write strobe stays high
    repeat (2) @(posedge pclk);
    r = {host_data_oe, host_data_in};
    host_read_strobe_n <= 1'b1;
    @(posedge pclk);
    {chan1_select_n, chan2_select_n} <= 2'b11;
  endtask : rd
endmodule : hpdfg_host_model

// file: test/hpdfg_top_tb.sv
// Purpose: Self-checking bench for the host port decoder and fast gate.
// Assumes: The host model drives the pins; the bench speaks APB.
// Notes: Decode, read and gate cases run from one table.
`timescale 1ns/1ns
module hpdfg_top_tb;
  import hpdfg_pkg::*;
  typedef struct {int kind; int ch; logic a0; logic [7:0] b; logic [7:0] st;} hpdfg_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata, rd_d;
  logic pready, pslverr, err, host_data_oe, gate_output_pin, gate_output_oe, irq;
  logic chan1_select_n, chan2_select_n, host_read_strobe_n, host_write_strobe_n, host_addr_bit;
  logic [BYTE_W-1:0] host_data_in, host_data_out;
  logic [8:0] hr;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Kind 0 host write, 1 host read, 2 gate step with st holding full flag and gate.
  hpdfg_row_t rows[21] = '{'{0, 1, 0, 8'h5a, 8'h02}, '{0, 1, 1, 8'ha5, 8'h0a}, '{0, 2, 1, 8'h3c, 8'h0a},
    '{0, 2, 0, 8'hc3, 8'h02}, '{1, 1, 0, 8'h96, 8'h09}, '{1, 2, 0, 8'h69, 8'h01},
    '{2, 1, 1, 8'hd1, 8'h1}, '{2, 1, 0, 8'h00, 8'h0}, '{2, 1, 1, 8'hff, 8'h0}, '{2, 1, 1, 8'hd1, 8'h0},
    '{2, 1, 0, 8'h02, 8'h1}, '{2, 1, 1, 8'h5a, 8'h3}, '{2, 1, 1, 8'hd1, 8'h1}, '{2, 1, 1, 8'h20, 8'h3},
    '{2, 1, 1, 8'hd1, 8'h1}, '{2, 1, 1, 8'hd1, 8'h1}, '{2, 1, 0, 8'hfd, 8'h0}, '{2, 1, 1, 8'hff, 8'h0},
    '{2, 1, 0, 8'h02, 8'h2}, '{2, 2, 1, 8'hd1, 8'h2}, '{2, 2, 0, 8'h02, 8'h2}};

  hpdfg_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .chan1_select_n, .chan2_select_n, .host_read_strobe_n, .host_write_strobe_n, .host_addr_bit,
    .host_data_in, .host_data_out, .host_data_oe, .gate_output_pin, .gate_output_oe, .irq);
  hpdfg_host_model host_u (.pclk, .chan1_select_n, .chan2_select_n, .host_read_strobe_n,
    .host_write_strobe_n, .host_addr_bit, .host_data_in, .host_data_out, .host_data_oe);

  // Clock and hang guard.
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      num_errors++;
      print_verdict();
    end
  end

  // Counts one compare and reports a mismatch.
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One APB transfer held until ready is sampled high.
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_d = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Register read compared with an expected word.
  task automatic rchk(input string nm, input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    check(nm, rd_d, exp);
  endtask : rchk

  // Prints counts and verdict, then stops.
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  // Main sequence: table first, then hand-written cases.
  initial begin
    hpdfg_row_t r;
    logic [15:0] off;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, ADDR_SYS_CONTROL, 32'h2);
    apb(1'b1, ADDR_IRQ_MASK, 32'h3);
    apb(1'b1, ADDR_GATE_PORT, 32'h3);
    apb(1'b1, ADDR_HOST_PORT_CONTROL, 32'h1);
    repeat (3) @(posedge pclk);
    check("gate at enable", {gate_output_oe, gate_output_pin}, 2'b11);
    foreach (rows[i]) begin
      r = rows[i];
      off = (r.ch == 2) ? 16'h4 : 16'h0;
      if (r.kind == 1) begin
        apb(1'b1, ADDR_CHAN1_OUT + off, {24'h0, r.b});
        host_u.rd(r.ch, 1'b1, hr);
        check("host status", hr, {1'b1, r.st});
        host_u.rd(r.ch, 1'b0, hr);
        check("host data", hr, {1'b1, r.b});
        rchk("status after read", ADDR_CHAN1_STAT + off, r.st & 8'hfc);
      end else begin
        host_u.wr(r.ch, r.a0, r.b);
        repeat (2) @(posedge pclk);
        if (r.kind == 0) begin
          check("irq pin", irq, 1);
          rchk("status", ADDR_CHAN1_STAT + off, r.st);
          rchk("input", ADDR_CHAN1_IN + off, r.b);
          rchk("status after read", ADDR_CHAN1_STAT + off, r.st & 8'hfc);
          rchk("irq status", ADDR_IRQ_STATUS, r.ch);
        end else begin
          check("gate", gate_output_pin, r.st[0]);
          apb(1'b0, ADDR_CHAN1_STAT + off, '0);
          check("input full", rd_d[1], r.st[1]);
          rchk("input", ADDR_CHAN1_IN + off, r.b);
        end
      end
      $display("test row %0d finished", i);
    end
    apb(1'b0, 16'hff30, '0);
    check("unmapped", {err, rd_d}, 33'h1_0000_0000);
    apb(1'b1, ADDR_HOST_PORT_CONTROL, 32'h0);
    host_u.wr(1, 1'b1, 8'hd1);
    host_u.wr(1, 1'b0, 8'h00);
    repeat (3) @(posedge pclk);
    check("gate from port data", gate_output_pin, 1);
    apb(1'b1, ADDR_GATE_PORT, 32'h2);
    repeat (3) @(posedge pclk);
    check("gate by software", gate_output_pin, 0);
    $display("test gate off finished");
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    apb(1'b0, ADDR_IRQ_STATUS, '0);
    host_u.wr(2, 1'b0, 8'h44);
    repeat (3) @(posedge pclk);
    check("masked irq", irq, 0);
    rchk("irq status", ADDR_IRQ_STATUS, 32'h2);
    apb(1'b1, ADDR_SYS_CONTROL, 32'h0);
    host_u.wr(2, 1'b0, 8'h77);
    rchk("input when off", ADDR_CHAN2_IN, 32'h44);
    host_u.rd(1, 1'b0, hr);
    check("drive when off", hr[8], 0);
    $display("test mask and disable finished");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    check("reset outputs", {gate_output_pin, gate_output_oe, host_data_oe, irq, pready}, 5'b10000);
    presetn <= 1'b1;
    rchk("gate port", ADDR_GATE_PORT, {30'h0, RST_GATE_PORT});
    apb(1'b0, ADDR_HOST_PORT_CONTROL, '0);
    check("fast gate enable", rd_d[0], 0);
    rchk("status reset", ADDR_CHAN1_STAT, 32'h0);
    $display("test second reset finished");
    print_verdict();
  end
endmodule : hpdfg_top_tb
